// >>> core/bwc_pkg.sv
// Constants and types shared by the bus wait-state control block
package bwc_pkg;

  // ------------------------------------------------------------------
  // Widths and sizes
  // ------------------------------------------------------------------
  localparam int ADDR_W = 20;        // Physical address width
  localparam int DATA_W = 16;        // External data bus width
  localparam int QUEUE_BYTES = 6;    // Prefetch queue depth in bytes
  localparam int QPTR_W = 3;         // Queue pointer width
  localparam int QCNT_W = 3;         // Queue fill count width

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] FETCH_ADDR_RST = 20'h0_0000;
  localparam logic [QCNT_W-1:0] QCNT_RST = 3'h0;
  localparam logic [QPTR_W-1:0] QPTR_RST = 3'h0;

  // ------------------------------------------------------------------
  // Bus states and cycle owners
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    TS_IDLE,
    TS_T1,
    TS_T2,
    TS_T3,
    TS_TW,
    TS_T4
  } bwc_tstate_t;

  typedef enum logic [1:0] {
    OWN_FETCH,
    OWN_EXEC,
    OWN_DMA
  } bwc_owner_t;

endpackage

// >>> core/bwc_wait_ctrl.sv
// Bus unit wait-state control with ready synchroniser and prefetch queue
module bwc_wait_ctrl (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic async_ready_in_i,
  input wire logic sync_ready_in_i,
  input wire logic exec_req_i,
  input wire logic exec_write_i,
  input wire logic exec_word_i,
  input wire logic exec_ign_ready_i,
  input wire logic [bwc_pkg::ADDR_W-1:0] exec_addr_i,
  input wire logic [bwc_pkg::DATA_W-1:0] exec_wdata_i,
  input wire logic dma_req_i,
  input wire logic dma_write_i,
  input wire logic dma_word_i,
  input wire logic dma_ign_ready_i,
  input wire logic [bwc_pkg::ADDR_W-1:0] dma_addr_i,
  input wire logic [bwc_pkg::DATA_W-1:0] dma_wdata_i,
  input wire logic fetch_ign_ready_i,
  input wire logic jump_i,
  input wire logic [bwc_pkg::ADDR_W-1:0] jump_addr_i,
  input wire logic queue_pop_i,
  input wire logic [bwc_pkg::DATA_W-1:0] bus_rdata_i,
  output bwc_pkg::bwc_tstate_t t_state_o,
  output logic bus_start_o,
  output logic [bwc_pkg::ADDR_W-1:0] bus_addr_o,
  output logic bus_write_o,
  output logic bus_word_o,
  output logic [bwc_pkg::DATA_W-1:0] bus_wdata_o,
  output logic exec_ack_o,
  output logic dma_ack_o,
  output logic [bwc_pkg::DATA_W-1:0] rdata_o,
  output logic queue_valid_o,
  output logic [7:0] queue_byte_o
);
  import bwc_pkg::*;

  // ------------------------------------------------------------------
  // Ready path
  // ------------------------------------------------------------------
  logic resolve_reg;
  logic resolve_next;
  logic ready_reg;
  logic ready_next;

  // The live async level bypasses the resolver once it has seen high,
  // so a slow device gets an extra phase to pull ready back low.
  always_comb begin
    resolve_next = async_ready_in_i;
    ready_next = (resolve_reg & async_ready_in_i)
                 | sync_ready_in_i;
  end

  // Ready flop captures every edge; only T3/TW states consume it
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      resolve_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      resolve_reg <= resolve_next;
      ready_reg <= ready_next;
    end
  end

  // ------------------------------------------------------------------
  // Bus cycle sequencer and prefetch queue
  // ------------------------------------------------------------------
  bwc_tstate_t state_reg;
  bwc_tstate_t state_next;
  bwc_owner_t owner_reg;
  bwc_owner_t owner_next;
  logic ign_reg;
  logic ign_next;
  logic discard_reg;
  logic discard_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic write_reg;
  logic write_next;
  logic word_reg;
  logic word_next;
  logic start_reg;
  logic start_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] wdata_next;
  logic exec_ack_reg;
  logic exec_ack_next;
  logic dma_ack_reg;
  logic dma_ack_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [ADDR_W-1:0] faddr_reg;
  logic [ADDR_W-1:0] faddr_next;
  logic [7:0] qmem_reg [QUEUE_BYTES];
  logic [7:0] qmem_next [QUEUE_BYTES];
  logic [QPTR_W-1:0] rptr_reg;
  logic [QPTR_W-1:0] rptr_next;
  logic [QPTR_W-1:0] wptr_reg;
  logic [QPTR_W-1:0] wptr_next;
  logic [QCNT_W-1:0] qcnt_reg;
  logic [QCNT_W-1:0] qcnt_next;
  logic qvalid_reg;
  logic qvalid_next;
  logic [7:0] qbyte_reg;
  logic [7:0] qbyte_next;

  // Queue pointer step with wrap at the non power-of-two depth
  function automatic logic [QPTR_W-1:0] ptr_inc(
    input logic [QPTR_W-1:0] p
  );
    return (p == QPTR_W'(QUEUE_BYTES - 1)) ? QPTR_RST : p + 3'h1;
  endfunction

  // Next-state logic: ready decision, queue update, then arbitration.
  // Arbitration looks at the queue after this cycle's push so a full
  // queue is seen before another fetch is launched.
  always_comb begin
    logic rdy_ok;
    logic done;
    logic can_start;
    logic exec_live;
    logic dma_live;
    logic fetch_room;
    rdy_ok = 1'b0;
    done = 1'b0;
    can_start = 1'b0;
    exec_live = 1'b0;
    dma_live = 1'b0;
    fetch_room = 1'b0;
    state_next = state_reg;
    owner_next = owner_reg;
    ign_next = ign_reg;
    discard_next = discard_reg;
    addr_next = addr_reg;
    write_next = write_reg;
    word_next = word_reg;
    wdata_next = wdata_reg;
    start_next = 1'b0;
    exec_ack_next = 1'b0;
    dma_ack_next = 1'b0;
    rdata_next = rdata_reg;
    faddr_next = faddr_reg;
    qmem_next = qmem_reg;
    rptr_next = rptr_reg;
    wptr_next = wptr_reg;
    qcnt_next = qcnt_reg;

    // Pop by the execution unit runs beside bus activity
    if (queue_pop_i && qvalid_reg) begin
      rptr_next = ptr_inc(rptr_reg);
      qcnt_next = qcnt_next - 3'h1;
    end

    // Ready is consulted only in T3 and TW; edges elsewhere are unseen
    rdy_ok = ready_reg | ign_reg;
    case (state_reg)
      TS_T1: begin
        state_next = TS_T2;
      end
      TS_T2: begin
        state_next = TS_T3;
      end
      TS_T3, TS_TW: begin
        if (rdy_ok) begin
          state_next = TS_T4;
          done = 1'b1;
        end else begin
          state_next = TS_TW;
        end
      end
      TS_T4: begin
        state_next = TS_IDLE;
        can_start = 1'b1;
      end
      TS_IDLE: begin
        can_start = 1'b1;
      end
      default: begin
        state_next = TS_IDLE;
      end
    endcase

    // Data is taken at the edge that ends the last T3/TW
    if (done) begin
      rdata_next = bus_rdata_i;
      case (owner_reg)
        OWN_EXEC: begin
          exec_ack_next = 1'b1;
        end
        OWN_DMA: begin
          dma_ack_next = 1'b1;
        end
        default: begin
          if (!discard_reg && !jump_i) begin
            qmem_next[wptr_reg] = bus_rdata_i[7:0];
            wptr_next = ptr_inc(wptr_reg);
            qcnt_next = qcnt_next + 3'h1;
            if (word_reg) begin
              qmem_next[wptr_next] = bus_rdata_i[15:8];
              wptr_next = ptr_inc(wptr_next);
              qcnt_next = qcnt_next + 3'h1;
            end
          end
        end
      endcase
    end

    // A jump empties the queue and drops any fetch still on the bus
    if (jump_i) begin
      rptr_next = QPTR_RST;
      wptr_next = QPTR_RST;
      qcnt_next = QCNT_RST;
      faddr_next = jump_addr_i;
      if (owner_reg == OWN_FETCH && !(state_reg inside {TS_IDLE, TS_T4})) begin
        discard_next = 1'b1;
      end
    end

    // Requests already acknowledged are not restarted in T4
    exec_live = exec_req_i && !exec_ack_reg;
    dma_live = dma_req_i && !dma_ack_reg;
    fetch_room = (qcnt_next <= QCNT_W'(QUEUE_BYTES - 2));

    // Priority: DMA, execution unit, then prefetch; else stay idle
    if (can_start && !jump_i) begin
      if (dma_live) begin
        state_next = TS_T1;
        owner_next = OWN_DMA;
        addr_next = dma_addr_i;
        write_next = dma_write_i;
        word_next = dma_word_i;
        wdata_next = dma_wdata_i;
        ign_next = dma_ign_ready_i;
      end else if (exec_live) begin
        state_next = TS_T1;
        owner_next = OWN_EXEC;
        addr_next = exec_addr_i;
        write_next = exec_write_i;
        word_next = exec_word_i;
        wdata_next = exec_wdata_i;
        ign_next = exec_ign_ready_i;
      end else if (fetch_room) begin
        state_next = TS_T1;
        owner_next = OWN_FETCH;
        addr_next = faddr_next;
        write_next = 1'b0;
        word_next = ~faddr_next[0];
        ign_next = fetch_ign_ready_i;
        faddr_next = faddr_next + ADDR_W'(faddr_next[0] ? 1 : 2);
      end
      start_next = (state_next == TS_T1);
      discard_next = 1'b0;
    end

    // Registered view of the queue head for the execution unit
    qvalid_next = (qcnt_next != QCNT_RST);
    qbyte_next = qmem_next[rptr_next];
  end

  // Register the sequencer and queue state
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg <= TS_IDLE;
      owner_reg <= OWN_FETCH;
      ign_reg <= 1'b0;
      discard_reg <= 1'b0;
      addr_reg <= FETCH_ADDR_RST;
      write_reg <= 1'b0;
      word_reg <= 1'b0;
      wdata_reg <= 16'h0000;
      start_reg <= 1'b0;
      exec_ack_reg <= 1'b0;
      dma_ack_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      faddr_reg <= FETCH_ADDR_RST;
      for (int i = 0; i < QUEUE_BYTES; i++) begin
        qmem_reg[i] <= 8'h00;
      end
      rptr_reg <= QPTR_RST;
      wptr_reg <= QPTR_RST;
      qcnt_reg <= QCNT_RST;
      qvalid_reg <= 1'b0;
      qbyte_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      owner_reg <= owner_next;
      ign_reg <= ign_next;
      discard_reg <= discard_next;
      addr_reg <= addr_next;
      write_reg <= write_next;
      word_reg <= word_next;
      wdata_reg <= wdata_next;
      start_reg <= start_next;
      exec_ack_reg <= exec_ack_next;
      dma_ack_reg <= dma_ack_next;
      rdata_reg <= rdata_next;
      faddr_reg <= faddr_next;
      qmem_reg <= qmem_next;
      rptr_reg <= rptr_next;
      wptr_reg <= wptr_next;
      qcnt_reg <= qcnt_next;
      qvalid_reg <= qvalid_next;
      qbyte_reg <= qbyte_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all straight from flops
  // ------------------------------------------------------------------
  assign t_state_o = state_reg;
  assign bus_start_o = start_reg;
  assign bus_addr_o = addr_reg;
  assign bus_write_o = write_reg;
  assign bus_word_o = word_reg;
  assign bus_wdata_o = wdata_reg;
  assign exec_ack_o = exec_ack_reg;
  assign dma_ack_o = dma_ack_reg;
  assign rdata_o = rdata_reg;
  assign queue_valid_o = qvalid_reg;
  assign queue_byte_o = qbyte_reg;

endmodule

// >>> test/bwc_wait_ctrl_properties.sv
// Concurrent checks on the wait-state control ports
module bwc_wait_ctrl_properties
  import bwc_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic async_ready_in_i,
  input wire logic sync_ready_in_i,
  input wire logic exec_ign_ready_i,
  input wire logic dma_ign_ready_i,
  input wire logic fetch_ign_ready_i,
  input wire bwc_tstate_t t_state_o,
  input wire logic bus_start_o,
  input wire logic bus_word_o,
  input wire logic [ADDR_W-1:0] bus_addr_o,
  input wire logic exec_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic resolve_q;
  logic ready_q;
  logic samp;
  logic ign;
  // Reference ready capture: only the rise of async ready is resolved
  always_ff @(posedge clock_i) begin
    resolve_q <= async_ready_in_i;
    ready_q <= (resolve_q & async_ready_in_i) | sync_ready_in_i;
  end
  assign samp = t_state_o inside {TS_T3, TS_TW};
  assign ign = exec_ign_ready_i | dma_ign_ready_i | fetch_ign_ready_i;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  // ------------------------------------------------------------
  // Cycle shape and ready sampling
  // ------------------------------------------------------------
  cycle_order_a: assert property (t_state_o == TS_T1 |=>
    t_state_o == TS_T2 ##1 t_state_o == TS_T3) else $error("bad T1 order");
  start_pulse_a: assert property (t_state_o == TS_T1 |-> bus_start_o &&
    $past(t_state_o) inside {TS_IDLE, TS_T4}) else $error("bad T1 entry");
  ready_end_a: assert property (samp && ready_q |=>
    t_state_o == TS_T4) else $error("ready seen but no T4");
  wait_ins_a: assert property (samp && !ready_q && !ign |=>
    t_state_o == TS_TW) else $error("not ready but no wait");
  ack_t4_a: assert property (exec_ack_o |-> t_state_o == TS_T4 &&
    $past(samp)) else $error("ack outside T4");
  t4_next_a: assert property (t_state_o == TS_T4 |=>
    t_state_o inside {TS_IDLE, TS_T1}) else $error("bad state after T4");
  word_even_a: assert property (bus_start_o && bus_word_o |->
    !bus_addr_o[0]) else $error("word access at odd address");
  addr_hold_a: assert property (t_state_o inside {TS_T2, TS_T3, TS_TW,
    TS_T4} |-> $stable(bus_addr_o)) else $error("address moved in cycle");
  // Main scenarios reached
  cover property (t_state_o == TS_TW ##1 t_state_o == TS_TW);
  cover property (exec_ack_o);
  cover property (t_state_o == TS_IDLE [*3]);
endmodule

// >>> test/bwc_ready_dev.sv
// Slow device model that returns ready after a set number of waits
module bwc_ready_dev
  import bwc_pkg::*;
(
  input wire logic clock_i,
  input wire bwc_tstate_t t_state_o,
  input wire logic bus_start_o,
  input wire logic [3:0] waits_i,
  input wire logic use_async_i,
  input wire logic drop_i,
  output logic async_o,
  output logic sync_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  int thr;
  logic busy;
  // Falling-edge update keeps setup to the sampling rise; not-ready idle
  always @(negedge clock_i) begin
    cnt = bus_start_o ? 0 : cnt + 1;
    thr = use_async_i ? waits_i : waits_i + 1;
    busy = t_state_o inside {TS_T1, TS_T2, TS_T3, TS_TW};
    sync_o <= !use_async_i && busy && cnt >= thr;
    async_o <= use_async_i && busy && cnt >= thr
      && !(drop_i && cnt == thr + 1);
  end
endmodule

// >>> test/bwc_wait_ctrl_test.sv
// Self-checking bench for the bus wait-state control block
module bwc_wait_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import bwc_pkg::*;
  logic clock_i = 0;
  logic sys_rst_i = 1;
  logic exec_req_i = 0, exec_write_i = 0, exec_word_i = 0, dma_req_i = 0;
  logic dma_write_i = 0, dma_word_i = 0, jump_i = 0, queue_pop_i = 1;
  logic exec_ign_ready_i = 0, dma_ign_ready_i = 0, fetch_ign_ready_i = 0;
  logic [ADDR_W-1:0] exec_addr_i = '0, dma_addr_i = '0, jump_addr_i = '0;
  logic [DATA_W-1:0] exec_wdata_i = '0, dma_wdata_i = '0, bus_rdata_i = '0;
  logic async_ready_in_i, sync_ready_in_i, use_async = 0, drop = 0;
  logic [3:0] waits = 0;
  bwc_tstate_t t_state_o;
  logic bus_start_o, bus_write_o, bus_word_o, exec_ack_o, dma_ack_o;
  logic queue_valid_o;
  logic [ADDR_W-1:0] bus_addr_o;
  logic [DATA_W-1:0] bus_wdata_o, rdata_o;
  logic [7:0] queue_byte_o;
  int num_errors = 0;
  int checked = 0;
  int len;
  bwc_wait_ctrl DUT (.clock_i, .sys_rst_i, .async_ready_in_i,
    .sync_ready_in_i, .exec_req_i, .exec_write_i, .exec_word_i,
    .exec_ign_ready_i, .exec_addr_i, .exec_wdata_i, .dma_req_i,
    .dma_write_i, .dma_word_i, .dma_ign_ready_i, .dma_addr_i, .dma_wdata_i,
    .fetch_ign_ready_i, .jump_i, .jump_addr_i, .queue_pop_i, .bus_rdata_i,
    .t_state_o, .bus_start_o, .bus_addr_o, .bus_write_o, .bus_word_o,
    .bus_wdata_o, .exec_ack_o, .dma_ack_o, .rdata_o, .queue_valid_o,
    .queue_byte_o);
  bwc_ready_dev slow_dev (.clock_i, .t_state_o, .bus_start_o,
    .waits_i(waits), .use_async_i(use_async), .drop_i(drop),
    .async_o(async_ready_in_i), .sync_o(sync_ready_in_i));
  // 25 MHz processor clock
  initial begin
    forever #20 clock_i = ~clock_i;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic give_up();
    num_errors++;
    stop_test();
  endtask
  // Waits for a fresh T1; a hang here ends the run
  task automatic next_start();
    int i;
    for (i = 0; i < 60 && bus_start_o !== 1'b1; i++) @(negedge clock_i);
    if (i == 60) give_up();
  endtask
  // Length of the next whole cycle, counted from T1 as zero to T4
  task automatic len_is(int w, bit a, bit d, int e);
    int i;
    waits = 4'(w);
    use_async = a;
    drop = d;
    for (i = 0; i < 2 && t_state_o === TS_T1; i++) @(negedge clock_i);
    next_start();
    for (len = 0; len < 60 && t_state_o !== TS_T4; len++) @(negedge clock_i);
    check("cycle length", len, e);
    if (len == 60) give_up();
  endtask
  task automatic sync_waits();
    len_is(0, 0, 0, 3);
    len_is(1, 0, 0, 4);
    len_is(7, 0, 0, 10);
  endtask
  task automatic async_waits();
    len_is(0, 1, 0, 3);
    len_is(2, 1, 0, 5);
    len_is(1, 1, 1, 6);
  endtask
  // Ignored ready lets cycles end although the device never answers
  task automatic ignore_ready();
    int i;
    len_is(0, 0, 0, 3);
    waits = 4'hF;
    {exec_ign_ready_i, dma_ign_ready_i, fetch_ign_ready_i} = 3'b111;
    {dma_word_i, exec_write_i, exec_word_i} = 3'b111;
    dma_addr_i = 20'h0_4000;
    bus_rdata_i = 16'hA55A;
    exec_addr_i = 20'h1_2340;
    exec_wdata_i = 16'h3C96;
    {dma_req_i, exec_req_i} = 2'b11;
    for (i = 0; i < 40 && (dma_req_i || exec_req_i); i++) begin
      @(negedge clock_i);
      if (dma_ack_o === 1'b1) begin
        check("dma read data", rdata_o, 16'hA55A);
        check("dma read", {bus_addr_o, bus_write_o}, {20'h0_4000, 1'b0});
        dma_req_i = 0;
      end
      if (exec_ack_o === 1'b1) begin
        check("exec address", bus_addr_o, 20'h1_2340);
        check("exec data", bus_wdata_o, 16'h3C96);
        check("exec write", bus_write_o, 1'b1);
        exec_req_i = 0;
      end
    end
    if (i == 40) give_up();
    len_is(15, 0, 0, 3);
    waits = 4'h0;
    {exec_ign_ready_i, dma_ign_ready_i, fetch_ign_ready_i} = 3'b000;
  endtask
  // Full queue idles the bus; an odd jump target takes a byte fetch
  task automatic idle_and_jump();
    int i;
    queue_pop_i = 0;
    for (i = 0; i < 80 && t_state_o !== TS_IDLE; i++) @(negedge clock_i);
    if (i == 80) give_up();
    repeat (6) @(negedge clock_i);
    check("idle state", t_state_o, TS_IDLE);
    check("queue valid", queue_valid_o, 1'b1);
    jump_addr_i = 20'h0_0101;
    bus_rdata_i = 16'h1234;
    jump_i = 1;
    @(negedge clock_i);
    jump_i = 0;
    next_start();
    check("odd fetch", {bus_addr_o, bus_word_o}, {20'h0_0101, 1'b0});
    @(negedge clock_i);
    next_start();
    check("even fetch", {bus_addr_o, bus_word_o}, {20'h0_0102, 1'b1});
    check("queue head", queue_byte_o, 8'h34);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(negedge clock_i);
    sys_rst_i = 0;
    sync_waits();
    async_waits();
    ignore_ready();
    idle_and_jump();
    stop_test();
  end
endmodule
bind bwc_wait_ctrl bwc_wait_ctrl_properties chk (.clock_i, .sys_rst_i,
  .async_ready_in_i, .sync_ready_in_i, .exec_ign_ready_i, .dma_ign_ready_i,
  .fetch_ign_ready_i, .t_state_o, .bus_start_o, .bus_word_o, .bus_addr_o,
  .exec_ack_o);
